// File: bench/spi_far_slave.sv
`timescale 1ns/1ps
`default_nettype none

module spi_far_slave (
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        edge_mode,
  input  wire logic        load,
  input  wire logic [15:0] reply,
  input  wire logic [4:0]  bits,
  output logic             miso,
  output logic [15:0]      rx
);
  logic [4:0] idx;

  // shift out on one edge, sample on the other
  always @(sck or posedge load)
  begin
    if (load)
      idx = 5'h00;
    else if (sck === edge_mode)
      idx = idx + 5'h01;
    else
      rx = {rx[14:0], mosi};
  end

  // Past the frame the line toggles so stale bits cannot pass
  assign miso = (idx < bits) ? reply[bits - 5'h01 - idx] : idx[0];
endmodule
`default_nettype wire

// File: bench/sync_serial_port_8_16_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_port_defines.svh"

module sync_serial_port_8_16_test;
  localparam logic [25:0] A_DAT = {`SSP_DATA_IDX, 2'h0};
  localparam logic [25:0] A_CTL = {`SSP_CTRL_IDX, 2'h0};
  localparam logic [25:0] A_STA = {`SSP_STAT_IDX, 2'h0};
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [25:0] awaddr = 26'h0, araddr = 26'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h3;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, far_miso;
  logic        tb_sck = 1'h0, tb_mosi = 1'h0, slave_select_n = 1'h1, emode = 1'h0, load = 1'h0;
  logic [15:0] rep = 16'h0, far_rx;
  logic [4:0]  fbits = 5'h08;
  int          pulses = 0, num_errors = 0, checks_done = 0;
  wire         sck_w = sck_oe_n ? tb_sck : sck_out;
  wire         mosi_w = mosi_oe_n ? tb_mosi : mosi_out;
  wire         miso_w = miso_oe_n ? far_miso : miso_out;

  sync_serial_port u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .shift_clock_pin_in(sck_w), .shift_clock_pin_out(sck_out), .shift_clock_pin_oe_n(sck_oe_n),
    .master_out_slave_in_pin_in(mosi_w), .master_out_slave_in_pin_out(mosi_out),
    .master_out_slave_in_pin_oe_n(mosi_oe_n), .master_in_slave_out_pin_in(miso_w),
    .master_in_slave_out_pin_out(miso_out), .master_in_slave_out_pin_oe_n(miso_oe_n),
    .slave_select_n, .irq);
  spi_far_slave u_far (.sck(sck_w), .mosi(mosi_w), .edge_mode(emode), .load, .reply(rep),
    .bits(fbits), .miso(far_miso), .rx(far_rx));

  always #10 aclk = ~aclk;
  always @(posedge sck_w) pulses++;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for the answer as long as it takes; only the watchdog ends a hang
  task automatic wr(input logic [25:0] a, input logic [15:0] d, input logic [1:0] er = `SSP_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a; wdata <= {16'h0, d}; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [25:0] a, output logic [31:0] d, input logic [1:0] er = `SSP_RESP_OKAY);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    rready <= 1'h0;
  endtask

  task automatic rchk(input string what, input logic [25:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask

  task automatic xfer(input logic [15:0] tx, input int nb);
    int n;
    pulses = 0; n = 0;
    wr(A_DAT, tx);
    while (pulses < nb && n < 2000) @(posedge aclk) n++;
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rchk("ctrl reset", A_CTL, 32'h0);
    rchk("stat reset", A_STA, 32'h0);
    rd(26'h0, d, `SSP_RESP_SLVERR);
    wr(A_CTL, 16'hfffe);
    rchk("ctrl back", A_CTL, 32'hfffe);
    wr(A_CTL, 16'h0);
  endtask

  task automatic t_master(input logic m, input logic idl, input logic w16, input logic [15:0] tx, rp);
    logic [15:0] k;
    int nb;
    k = w16 ? 16'hffff : 16'h00ff;
    nb = w16 ? 16 : 8;
    wr(A_CTL, {7'h02, idl, m, 4'h0, w16, 2'h2});
    wr(A_CTL, {7'h02, idl, m, 4'h0, w16, 2'h3});
    emode <= m; fbits <= w16 ? 5'h10 : 5'h08; rep <= rp; load <= 1'h1;
    @(posedge aclk) load <= 1'h0;
    xfer(tx, nb);
    chk("pulses", nb, pulses);
    chk("idle level", {31'h0, idl}, {31'h0, sck_w});
    chk("far rx", {16'h0, tx & k}, {16'h0, far_rx & k});
    rchk("stat done", A_STA, 32'h2);
    rchk("rx word", A_DAT, {16'h0, rp & k});
    rchk("stat read", A_STA, 32'h0);
  endtask

  task automatic t_overrun;
    wr(A_CTL, 16'h0412);
    wr(A_CTL, 16'h0413);
    // Far side restarts: first word a7, then the toggling pattern 55
    emode <= 1'h0; fbits <= 5'h08; rep <= 16'h00a7; load <= 1'h1;
    @(posedge aclk) load <= 1'h0;
    repeat (3) xfer(16'h00c3, 8);
    rchk("overrun", A_STA, 32'h7);
    chk("irq ovr", 32'h1, {31'h0, irq});
    wr(A_STA, 16'h0);
    rchk("w0 keeps", A_STA, 32'h7);
    wr(A_STA, 16'h4);
    rchk("w1 clears", A_STA, 32'h3);
    // Narrow transfers keep the high byte left by the wide one
    rchk("rx word", A_DAT, 32'h0000_6ba7);
    rchk("reload", A_STA, 32'h2);
    rchk("reload word", A_DAT, 32'h0000_6b55);
    wr(A_CTL, 16'h0442);
    rchk("off", A_STA, 32'h0);
    chk("irq ready", 32'h1, {31'h0, irq});
  endtask

  task automatic sframe(input logic [7:0] v, output logic [7:0] got);
    tb_mosi <= v[7];
    for (int i = 7; i >= 0; i--)
    begin
      repeat (4) @(posedge aclk);
      got[i] = miso_w;
      tb_sck <= 1'h1;
      repeat (4) @(posedge aclk);
      tb_sck <= 1'h0;
      tb_mosi <= (i > 0) ? v[i - 1] : 1'h0;
    end
    repeat (6) @(posedge aclk);
  endtask

  task automatic t_slave;
    logic [7:0] got;
    wr(A_CTL, 16'h0001);
    wr(A_DAT, 16'h0096);
    chk("float", 32'h1, {31'h0, miso_oe_n});
    slave_select_n <= 1'h0;
    repeat (2) @(posedge aclk);
    chk("drive", 32'h0, {31'h0, miso_oe_n});
    // cut a frame after three clocks; the next one restarts at the MSB
    repeat (3)
    begin
      repeat (4) @(posedge aclk);
      tb_sck <= 1'h1;
      repeat (4) @(posedge aclk);
      tb_sck <= 1'h0;
    end
    repeat (4) @(posedge aclk);
    slave_select_n <= 1'h1;
    repeat (4) @(posedge aclk);
    slave_select_n <= 1'h0;
    sframe(8'h5a, got);
    chk("slave tx", 32'h96, {24'h0, got});
    rchk("slave rx", A_DAT, 32'h6b5a);
    slave_select_n <= 1'h1;
    wr(A_CTL, 16'h0000);
    wr(A_CTL, 16'h0009);
    slave_select_n <= 1'h0;
    sframe(8'h3c, got);
    chk("echo", 32'h3c, {24'h0, got});
    rchk("echo rx", A_DAT, 32'h6b3c);
    slave_select_n <= 1'h1;
  endtask

  task automatic conclude;
    if (num_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_master(1'h0, 1'h0, 1'h0, 16'h00a5, 16'h003c);
    t_master(1'h1, 1'h1, 1'h1, 16'h9a5c, 16'h6b21);
    t_overrun();
    t_slave();
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    conclude();
  end
endmodule

bind sync_serial_port sync_serial_port_properties #(.ADDR_W(ADDR_W)) u_props (.aclk, .aresetn, .awaddr,
  .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid, .arvalid, .arready, .rvalid,
  .shift_clock_pin_out, .shift_clock_pin_oe_n, .master_out_slave_in_pin_oe_n,
  .master_in_slave_out_pin_oe_n, .slave_select_n, .irq);
`default_nettype wire

// File: bench/sync_serial_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_port_defines.svh"

module sync_serial_port_properties #(
  parameter int ADDR_W = 26
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              shift_clock_pin_out,
  input wire logic              shift_clock_pin_oe_n,
  input wire logic              master_out_slave_in_pin_oe_n,
  input wire logic              master_in_slave_out_pin_oe_n,
  input wire logic              slave_select_n,
  input wire logic              irq
);
  sync_serial_port_pkg::ctrl_s ctrl;
  logic [ADDR_W-1:0]           aw_q;
  logic [15:0]                 w_q;
  logic                        sck_q;
  logic [7:0]                  run;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  always_ff @(posedge aclk)
  begin
    if (awvalid && awready)
      aw_q <= awaddr;
    if (wvalid && wready)
      w_q <= wdata[15:0];
  end

  // Shadow lags the design by one edge; checks skip that cycle via bvalid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= '0;
    else if ($rose(bvalid) && bresp == `SSP_RESP_OKAY && aw_q == {`SSP_CTRL_IDX, 2'h0})
      ctrl <= w_q;
  end

  // Known count after reset, else the first master toggle compares an unknown
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sck_q <= 1'b0;
      run   <= 8'h00;
    end
    else
    begin
      sck_q <= shift_clock_pin_out;
      if (shift_clock_pin_out != sck_q)
        run <= 8'h00;
      else if (run != 8'hff)
        run <= run + 8'h01;
    end
  end

  a_clk_dir: assert property (!bvalid |-> shift_clock_pin_oe_n == !ctrl.master_select)
    else $error("shift clock direction wrong");
  a_mosi_dir: assert property (!bvalid |-> master_out_slave_in_pin_oe_n == !ctrl.master_select)
    else $error("master data output direction wrong");
  a_idle_off: assert property (!bvalid && ctrl.master_select && !ctrl.port_enable
    |-> shift_clock_pin_out == ctrl.clock_idle_level) else $error("disabled clock not at idle level");
  a_miso_float: assert property (!bvalid && ctrl.port_enable && !ctrl.master_select && slave_select_n
    |-> master_in_slave_out_pin_oe_n) else $error("slave output driven while deselected");
  a_miso_drive: assert property (!bvalid && ctrl.port_enable && !ctrl.master_select && !slave_select_n
    |-> !master_in_slave_out_pin_oe_n) else $error("slave output not driven while selected");
  a_miso_off: assert property (!bvalid && !ctrl.port_enable && !ctrl.master_select
    |-> master_in_slave_out_pin_oe_n) else $error("disabled slave output driven");
  a_irq_ready: assert property (!bvalid && !ctrl.port_enable && ctrl.write_ready_irq_enable |-> irq)
    else $error("write ready interrupt missing");
  a_irq_quiet: assert property (!bvalid && !ctrl.write_ready_irq_enable && !ctrl.read_full_irq_enable
    && !ctrl.overrun_irq_enable |-> !irq) else $error("interrupt with all sources masked");
  a_half_period: assert property (!bvalid && ctrl.port_enable && ctrl.master_select
    && shift_clock_pin_out != sck_q |-> run >= 8'(ctrl.clock_divider_field)) else $error("half period short");
  a_read_answer: assert property (arvalid && arready && !rvalid |=> rvalid)
    else $error("read answer late");

  c_master: cover property (ctrl.master_select && ctrl.port_enable && shift_clock_pin_out != sck_q);
  c_slave: cover property (ctrl.port_enable && !ctrl.master_select && !slave_select_n);
  c_irq: cover property (ctrl.port_enable && irq);
endmodule
`default_nettype wire

// File: include/sync_serial_port_defines.svh
// How it works
// - Mode 0: drive on fall, sample on rise
// - Mode 1: drive on rise, sample on fall
// - Master clock rests at idle level
// - Bit 7 timing follows leading/trailing choice
// - Master write yields 8 or 16 pulses
// - Clock pin driven as master, input as slave
// - Slave output floats while select is high
// - Slave sends MSB first, 8/16 clocks
// - Echo retransmits input when data invalid
// - Without echo, always send data register
// - Select high restarts slave bit count
// - Interrupt on buffer full and enable
// - Interrupt while not busy and enabled
// - Interrupt on overrun and enable, master only
// - Disable clears busy, full, overrun flags; a slave-mode data write while disabled still sets busy
// - Disabled pins: idle clock, floating, known
// - Master select: 0 slave, 1 master
// - Width bit: 0 eight, 1 sixteen
// - Echo ignored in master mode
// - Data valid from write to transfer end
// - Clock divides by 2 times (field+1)
// - Read returns buffer, write loads shifter
// - Busy set by write, clears when stored
// - Read clears full unless word waiting
// - Overrun set on start while a word waits; W1C
`ifndef SYNC_SERIAL_PORT_DEFINES_SVH
`define SYNC_SERIAL_PORT_DEFINES_SVH

// Register indices; byte address is four times the index
`define SSP_DATA_IDX 24'hfffe60
`define SSP_CTRL_IDX 24'hfffe62
`define SSP_STAT_IDX 24'hfffe64

`define SSP_CTRL_RESET 16'h0000
`define SSP_WORD_RESET 16'h0000

`define SSP_STAT_BUSY_BIT 0
`define SSP_STAT_FULL_BIT 1
`define SSP_STAT_OVR_BIT  2

`define SSP_BITS_NARROW 5'h08
`define SSP_BITS_WIDE   5'h10

`define SSP_RESP_OKAY   2'h0
`define SSP_RESP_SLVERR 2'h2

`endif

// File: include/sync_serial_port_pkg.sv
`default_nettype none
package sync_serial_port_pkg;

  typedef struct packed {
    logic [6:0] clock_divider_field;
    logic       clock_idle_level;
    logic       clock_edge_mode;
    logic       write_ready_irq_enable;
    logic       read_full_irq_enable;
    logic       overrun_irq_enable;
    logic       echo_enable;
    logic       word_width_select;
    logic       master_select;
    logic       port_enable;
  } ctrl_s;

  typedef enum logic [1:0] {
    XFER_IDLE  = 2'b00,
    XFER_RUN   = 2'b01,
    XFER_STALL = 2'b10
  } xfer_state_e;

  typedef enum logic [1:0] {
    SEL_DATA = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_STAT = 2'b10,
    SEL_NONE = 2'b11
  } reg_sel_e;

endpackage
`default_nettype wire

// File: logic/sync_serial_port.sv
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_port_defines.svh"

module sync_serial_port #(
  parameter int ADDR_W = 26
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              shift_clock_pin_in,
  output logic                   shift_clock_pin_out,
  output logic                   shift_clock_pin_oe_n,
  input  wire logic              master_out_slave_in_pin_in,
  output logic                   master_out_slave_in_pin_out,
  output logic                   master_out_slave_in_pin_oe_n,
  input  wire logic              master_in_slave_out_pin_in,
  output logic                   master_in_slave_out_pin_out,
  output logic                   master_in_slave_out_pin_oe_n,
  input  wire logic              slave_select_n,
  output logic                   irq
);

  function automatic sync_serial_port_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'({`SSP_DATA_IDX, 2'b00}))
      decode = sync_serial_port_pkg::SEL_DATA;
    else if (a == ADDR_W'({`SSP_CTRL_IDX, 2'b00}))
      decode = sync_serial_port_pkg::SEL_CTRL;
    else if (a == ADDR_W'({`SSP_STAT_IDX, 2'b00}))
      decode = sync_serial_port_pkg::SEL_STAT;
    else
      decode = sync_serial_port_pkg::SEL_NONE;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw, input logic [3:0] s);
    merge16 = {s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
  endfunction

  // Top transmit bit: 15 when wide, 7 when narrow
  function automatic logic top_bit(input logic wide, input logic [15:0] v);
    top_bit = wide ? v[15] : v[7];
  endfunction

  sync_serial_port_pkg::ctrl_s       ctrl;
  sync_serial_port_pkg::xfer_state_e state;
  sync_serial_port_pkg::reg_sel_e    wsel;
  sync_serial_port_pkg::reg_sel_e    rsel;

  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_wr;
  logic              rd_take;
  logic              wr_data;
  logic              wr_ctrl;
  logic              wr_stat;
  logic              rd_data;

  logic [15:0] data_word;
  logic [15:0] tx;
  logic [15:0] rx;
  logic [15:0] rbuf;
  logic [15:0] pend;
  logic        busy;
  logic        read_buffer_full_flag;
  logic        overrun_flag;
  logic        data_valid;
  logic [4:0]  nsamp;
  logic [5:0]  nedge;
  logic [6:0]  div_cnt;
  logic        phase;
  logic        sclk_prev;

  logic        en;
  logic        mst;
  logic        wide;
  logic [4:0]  nbits;
  logic        out_lead;
  logic        m_tick;
  logic        m_lead;
  logic        m_trail;
  logic        s_act;
  logic        s_lvl;
  logic        s_lead;
  logic        s_trail;
  logic        lead;
  logic        trail;
  logic        din;
  logic        sample;
  logic        shift_out;
  logic        done;
  logic        start;
  logic        echo_now;
  logic [15:0] rx_next;
  logic [15:0] done_word;
  logic [15:0] wr_merged;

  assign en   = ctrl.port_enable;
  assign mst  = ctrl.master_select;
  assign wide = ctrl.word_width_select;
  assign nbits = wide ? `SSP_BITS_WIDE : `SSP_BITS_NARROW;

  // output edge is leading when mode and idle differ
  assign out_lead = ctrl.clock_edge_mode ^ ctrl.clock_idle_level;

  // half period of divider+1 system clocks
  assign m_tick  = en && mst && (state == sync_serial_port_pkg::XFER_RUN) &&
                   (div_cnt == ctrl.clock_divider_field);
  assign m_lead  = m_tick && !phase;
  assign m_trail = m_tick && phase;

  // Slave clock seen relative to idle level, so leading is 0 to 1
  assign s_lvl   = shift_clock_pin_in ^ ctrl.clock_idle_level;
  assign s_act   = en && !mst && !slave_select_n;
  assign s_lead  = s_act && s_lvl && !sclk_prev;
  assign s_trail = s_act && !s_lvl && sclk_prev && (state == sync_serial_port_pkg::XFER_RUN);

  assign lead  = m_lead || s_lead;
  assign trail = m_trail || s_trail;
  assign din   = mst ? master_in_slave_out_pin_in : master_out_slave_in_pin_in;

  // sample and drive edges follow the clock mode
  assign sample    = out_lead ? trail : lead;
  // first leading drive edge presents the MSB already loaded
  assign shift_out = (out_lead ? lead : trail) && (nsamp != 5'h00);

  assign rx_next   = {rx[14:0], din};
  assign done_word = sample ? rx_next : rx;

  // master ends after 2N edges, clock back at idle
  // slave ends at the Nth sample
  assign done = mst ? (m_tick && (nedge == {nbits, 1'b0} - 6'h01))
                    : (sample && (nsamp == nbits - 5'h01));

  assign start = mst ? (wr_data && en) :
                 (s_lead && (state != sync_serial_port_pkg::XFER_RUN));

  // echo only as slave with no valid data
  assign echo_now = !mst && ctrl.echo_enable && !data_valid;

  // Bus side
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !rvalid;
  assign do_wr   = aw_held && w_held && !bvalid;
  assign rd_take = arvalid && arready;
  assign wsel    = decode(aw_addr);
  assign rsel    = decode(araddr);
  assign wr_data = do_wr && (wsel == sync_serial_port_pkg::SEL_DATA);
  assign wr_ctrl = do_wr && (wsel == sync_serial_port_pkg::SEL_CTRL);
  assign wr_stat = do_wr && (wsel == sync_serial_port_pkg::SEL_STAT);
  assign rd_data = rd_take && (rsel == sync_serial_port_pkg::SEL_DATA);
  assign wr_merged = merge16(data_word, w_data, w_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (awvalid && awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end
    else if (do_wr)
      aw_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (wvalid && wready)
    begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end
    else if (do_wr)
      w_held <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= `SSP_RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid <= 1'b1;
      bresp  <= (wsel == sync_serial_port_pkg::SEL_NONE) ? `SSP_RESP_SLVERR : `SSP_RESP_OKAY;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  // data reads return the read buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `SSP_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid <= 1'b1;
      rresp  <= `SSP_RESP_OKAY;
      case (rsel)
        sync_serial_port_pkg::SEL_DATA: rdata <= {16'h0000, rbuf};
        sync_serial_port_pkg::SEL_CTRL: rdata <= {16'h0000, ctrl};
        sync_serial_port_pkg::SEL_STAT: rdata <= {29'h0000_0000, overrun_flag, read_buffer_full_flag, busy};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= `SSP_RESP_SLVERR;
        end
      endcase
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  // control layout; software changes it while disabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= `SSP_CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= merge16(ctrl, w_data, w_strb);
  end

  // writes load the shifter, not the read buffer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_word <= `SSP_WORD_RESET;
    else if (wr_data)
      data_word <= wr_merged;
  end

  // valid from write until the transfer ends
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_valid <= 1'b0;
    else if (wr_data)
      data_valid <= 1'b1;
    else if (done)
      data_valid <= 1'b0;
  end

  // Slave copy is reloaded while idle so each transfer starts from the word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx <= `SSP_WORD_RESET;
    else if (wr_data)
      tx <= wr_merged;
    else if (shift_out)
      tx <= {tx[14:0], 1'b0};
    else if (!mst && state != sync_serial_port_pkg::XFER_RUN)
      tx <= data_word;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rx <= `SSP_WORD_RESET;
    else if (sample)
      rx <= rx_next;
  end

  // select high restarts the slave count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      nsamp <= 5'h00;
    else if (!en || (!mst && slave_select_n) || done)
      nsamp <= 5'h00;
    else if (sample)
      nsamp <= nsamp + 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sclk_prev <= 1'b0;
    else if (!s_act)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= s_lvl;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= 7'h00;
      phase   <= 1'b0;
      nedge   <= 6'h00;
    end
    else if (!en || !mst || state != sync_serial_port_pkg::XFER_RUN || done)
    begin
      div_cnt <= 7'h00;
      phase   <= 1'b0;
      nedge   <= 6'h00;
    end
    else if (m_tick)
    begin
      div_cnt <= 7'h00;
      phase   <= !phase;
      nedge   <= nedge + 6'h01;
    end
    else
      div_cnt <= div_cnt + 7'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= sync_serial_port_pkg::XFER_IDLE;
      busy  <= 1'b0;
      read_buffer_full_flag   <= 1'b0;
      rbuf  <= `SSP_WORD_RESET;
      pend  <= `SSP_WORD_RESET;
    end
    else if (!en)
    begin
      state <= sync_serial_port_pkg::XFER_IDLE;
      busy  <= wr_data && !mst;
      read_buffer_full_flag   <= 1'b0;
    end
    else if (done)
    begin
      // busy clears only if the word could be stored
      if (!read_buffer_full_flag || rd_data)
      begin
        rbuf  <= wide ? done_word : {rbuf[15:8], done_word[7:0]};
        read_buffer_full_flag   <= 1'b1;
        busy  <= 1'b0;
        state <= sync_serial_port_pkg::XFER_IDLE;
      end
      else
      begin
        pend  <= done_word;
        state <= sync_serial_port_pkg::XFER_STALL;
      end
    end
    else if (start)
    begin
      // write or first slave edge sets busy
      state <= sync_serial_port_pkg::XFER_RUN;
      busy  <= 1'b1;
    end
    else if (!mst && slave_select_n && state == sync_serial_port_pkg::XFER_RUN)
      state <= sync_serial_port_pkg::XFER_IDLE;
    else if (rd_data)
    begin
      // waiting word reloads at once, flag stays set
      if (state == sync_serial_port_pkg::XFER_STALL)
      begin
        rbuf  <= wide ? pend : {rbuf[15:8], pend[7:0]};
        busy  <= 1'b0;
        state <= sync_serial_port_pkg::XFER_IDLE;
      end
      else
        read_buffer_full_flag <= 1'b0;
    end
    else if (wr_data)
      busy <= 1'b1;
  end

  // set wins over the write-one clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overrun_flag <= 1'b0;
    else if (!en)
      overrun_flag <= 1'b0;
    else if (start && mst && read_buffer_full_flag && state == sync_serial_port_pkg::XFER_STALL)
      overrun_flag <= 1'b1;
    else if (wr_stat && w_strb[0] && w_data[`SSP_STAT_OVR_BIT])
      overrun_flag <= 1'b0;
  end

  // clock pin driven as master, idle level outside transfers
  assign shift_clock_pin_out  = ctrl.clock_idle_level ^ (phase && en && mst);
  assign shift_clock_pin_oe_n = !mst;

  // master output holds zero while disabled
  assign master_out_slave_in_pin_out  = en && mst && top_bit(wide, tx);
  assign master_out_slave_in_pin_oe_n = !mst;

  // slave output driven only while selected
  assign master_in_slave_out_pin_out  = echo_now ? master_out_slave_in_pin_in : top_bit(wide, tx);
  assign master_in_slave_out_pin_oe_n = !(en && !mst && !slave_select_n);

  // level interrupt from flags and enables
  assign irq = (read_buffer_full_flag && ctrl.read_full_irq_enable) ||
               (!busy && ctrl.write_ready_irq_enable) ||
               (overrun_flag && ctrl.overrun_irq_enable);

endmodule
`default_nettype wire
